// >>> erf_defines.svh
/*
 Constants for the error record feature and enable register logic:
 offsets, field positions, encodings and reset values.
 Assumes it is included by its bare name wherever the constants are used.
*/
`ifndef ERF_DEFINES_SVH
`define ERF_DEFINES_SVH

`define ERF_FR_BASE_OFFSET    12'h000
`define ERF_RECORD_STRIDE     12'h040
`define ERF_ED_POS            0
`define ERF_FRX_POS           31
`define ERF_UC_POS            48
`define ERF_UEU_POS           49
`define ERF_UER_POS           50
`define ERF_UEO_POS           51
`define ERF_DE_POS            52
`define ERF_CE_LSB            53
`define ERF_ED_CONTROLLABLE   2'h2
`define ERF_ED_NONE           2'h0
`define ERF_ENABLE_RESET      1'h0

`endif

// >>> erf_pkg.sv
/*
 Types shared by the error record feature logic.
 Assumes erf_defines.svh is on the include path.
*/
package erf_pkg;

   typedef enum logic [1:0] {
      ERF_RD_LOW  = 2'b00,
      ERF_RD_HIGH = 2'b01,
      ERF_RD_64   = 2'b10,
      ERF_RD_MMIO = 2'b11
   } erf_rd_kind_t;

   typedef struct packed {
      logic          valid;
      erf_rd_kind_t  kind;
      logic [11:0]   addr;
   } erf_rd_req_t;

   typedef struct packed {
      logic [1:0]  ce_kinds;
      logic        postpone_error_support;
      logic        latent_restartable_support;
      logic        signal_recover_support;
      logic        unrecoverable_support;
      logic        uncontainable_support;
   } erf_support_t;

endpackage

// >>> erf_error_record_feature_regs.sv
/*
 Feature register and reporting enable bit of one error recording node.
 Assumes a single clock, system register and memory mapped read requests
 presented as one-cycle strobes, and an error recovery reset given as a
 synchronous pulse from logic on the same clock.
*/
// Function
// RULE_01 - Enable field controllable and bit clear: no recording, no signaling.
// RULE_02 - While disabled, keep writing correct check codes unless injection stops it.
// RULE_03 - While disabled, correction may continue silently; corrupt data may pass.
// RULE_04 - Enable bit takes a chosen cold reset value, kept over recovery reset.
// RULE_05 - Enable resets to zero so software enables after initialisation.
// RULE_06 - If enable resets to one, sibling controls need defined resets.
// RULE_07 - Without controllable enable the bit reads zero and ignores writes.
// RULE_08 - First record field non-zero in the first record, zero elsewhere.
// RULE_09 - Unimplemented records read the whole feature register as zero.
// RULE_10 - Memory mapped feature register sits at zero plus 64 per record.
// RULE_11 - Select index picks record; low, high or full 64-bit reads.
// RULE_12 - Non-first or absent records read zero in bits 63 to 2.
// RULE_13 - With extension flag, bits 54:53 give corrected error recording kinds.
// RULE_14 - With extension flag, bit 52 shows deferred error recording.
// RULE_15 - With extension flag, bit 51 shows latent or restartable recording.
// RULE_16 - With extension flag, bit 50 shows signaled or recoverable recording.
// RULE_17 - With extension flag, bit 49 shows unrecoverable recording.
// RULE_18 - With extension flag, bit 48 shows uncontainable recording.
// RULE_19 - Bits 63:55, 47:32 and unextended 54:48 are build constants.
// RULE_20 - Extension flag bit 31 set when 63:48 carry defined meanings.
// RULE_21 - Feature register is constant; writes to it change nothing.
`include "erf_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module erf_error_record_feature_regs #(
   parameter int unsigned        NUM_RECORDS   = 4,
   parameter int unsigned        FIRST_RECORD  = 0,
   parameter int unsigned        IMPL_RECORDS  = 4,
   parameter logic [1:0]         ED_FIELD      = `ERF_ED_CONTROLLABLE,
   parameter logic               FEATURE_EXTENSION_FLAG           = 1'b1,
   parameter erf_pkg::erf_support_t SUPPORT    = 7'b11_1_1_1_1_1,
   parameter logic [8:0]         IMPL_HI       = 9'h000,
   parameter logic [15:0]        IMPL_MID      = 16'h0000,
   parameter logic [6:0]         IMPL_EXT_OFF  = 7'h00,
   parameter logic [28:0]        LOW_FIELDS    = 29'h0000_0000,
   parameter logic               ENABLE_RESET  = `ERF_ENABLE_RESET
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             recovery_reset_i,
   input  wire logic [7:0]       record_select_index_i,
   input  wire erf_pkg::erf_rd_req_t rd_req_i,
   input  wire logic             ctrl_wr_i,
   input  wire logic [7:0]       ctrl_wr_record_i,
   input  wire logic             ctrl_wr_data_i,
   input  wire logic             fr_wr_i,
   input  wire logic             err_detect_i,
   input  wire logic             err_corrected_i,
   output logic                  rd_valid_o,
   output logic [63:0]           rd_data_o,
   output logic                  report_log_enable_o,
   output logic                  record_en_o,
   output logic                  signal_en_o,
   output logic                  check_code_gen_o,
   output logic                  silent_correct_o
);

   // Memory mapped slots decode six index bits, so at most 64 records
   if (NUM_RECORDS < 1 || NUM_RECORDS > 64 || IMPL_RECORDS > NUM_RECORDS
       || FIRST_RECORD >= NUM_RECORDS) begin : g_bad_records
      $error("erf: record parameters out of range");
   end
   // The owning record must never show an all-zero enable field
   if (ED_FIELD == `ERF_ED_NONE) begin : g_bad_enable_field
      $error("erf: enable field of the first record reads zero");
   end

   localparam logic CTRL_ENABLE = (ED_FIELD == `ERF_ED_CONTROLLABLE);

   ////////////////////////////////////////////////////////////////////////
   // Constant feature word of the first record
   function automatic logic [63:0] first_word();
      logic [63:0] w;
      w = 64'h0000_0000_0000_0000;
      w[1:0]   = ED_FIELD;                             // [RULE_08]
      w[30:2]  = LOW_FIELDS;
      w[`ERF_FRX_POS] = FEATURE_EXTENSION_FLAG;                           // [RULE_20]
      w[47:32] = IMPL_MID;                             // [RULE_19]
      w[63:55] = IMPL_HI;                              // [RULE_19]
      if (FEATURE_EXTENSION_FLAG) begin
         w[`ERF_CE_LSB+1:`ERF_CE_LSB] = SUPPORT.ce_kinds;        // [RULE_13]
         w[`ERF_DE_POS]  = SUPPORT.postpone_error_support;       // [RULE_14]
         w[`ERF_UEO_POS] = SUPPORT.latent_restartable_support;   // [RULE_15]
         w[`ERF_UER_POS] = SUPPORT.signal_recover_support;       // [RULE_16]
         w[`ERF_UEU_POS] = SUPPORT.unrecoverable_support;        // [RULE_17]
         w[`ERF_UC_POS]  = SUPPORT.uncontainable_support;        // [RULE_18]
      end else begin
         w[54:48] = IMPL_EXT_OFF;                      // [RULE_19]
      end
      return w;
   endfunction

   localparam logic [63:0] FIRST_WORD = first_word();

   // Only the first record FIRST_RECORD, if implemented, carries features; others read zero
   function automatic logic [63:0] feature_of(input logic [7:0] idx);
      logic [63:0] w;
      w = 64'h0000_0000_0000_0000;
      if (32'(idx) < IMPL_RECORDS && 32'(idx) == FIRST_RECORD)
         w = FIRST_WORD;                      // [RULE_09] [RULE_12]
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reporting enable bit
   logic report_log_enable;

   // Cold reset loads the build value; recovery reset leaves it alone
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         report_log_enable <= CTRL_ENABLE & ENABLE_RESET;  // [RULE_04] [RULE_05]
      end else if (ctrl_wr_i && !recovery_reset_i && CTRL_ENABLE
                   && 32'(ctrl_wr_record_i) == FIRST_RECORD) begin
         report_log_enable <= ctrl_wr_data_i;              // [RULE_07]
      end
   end
   // [RULE_06] This block holds no other control with an undefined reset.

   // Node gating outputs, registered
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         report_log_enable_o <= CTRL_ENABLE & ENABLE_RESET;
         record_en_o         <= 1'b0;
         signal_en_o         <= 1'b0;
         check_code_gen_o    <= 1'b1;
         silent_correct_o    <= 1'b0;
      end else begin
         report_log_enable_o <= report_log_enable;
         // Without a control the node is always reporting
         record_en_o <= (CTRL_ENABLE ? report_log_enable : 1'b1)
                        & err_detect_i;                    // [RULE_01]
         signal_en_o <= (CTRL_ENABLE ? report_log_enable : 1'b1)
                        & err_detect_i;                    // [RULE_01]
         // Check codes stay correct even while disabled
         check_code_gen_o <= 1'b1;                          // [RULE_02]
         // Correction runs silently when reporting is off
         silent_correct_o <= CTRL_ENABLE & ~report_log_enable
                             & err_corrected_i;             // [RULE_03]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path
   logic [63:0] next_rd_data;
   logic [63:0] sel_word;
   logic [63:0] mm_word;
   logic [11:0] mm_rel;

   always_comb begin
      sel_word = feature_of(record_select_index_i);        // [RULE_11]
      mm_rel   = rd_req_i.addr - `ERF_FR_BASE_OFFSET;
      mm_word  = 64'h0000_0000_0000_0000;
      // Only the aligned feature slot of each record answers
      if (mm_rel[5:0] == 6'h00)
         mm_word = feature_of({2'b00, mm_rel[11:6]});      // [RULE_10]
      next_rd_data = 64'h0000_0000_0000_0000;
      unique case (rd_req_i.kind)
         erf_pkg::ERF_RD_LOW:  next_rd_data = {32'h0000_0000, sel_word[31:0]};
         erf_pkg::ERF_RD_HIGH: next_rd_data = {32'h0000_0000, sel_word[63:32]};
         erf_pkg::ERF_RD_64:   next_rd_data = sel_word;
         erf_pkg::ERF_RD_MMIO: next_rd_data = mm_word;
      endcase
   end

   // Writes to the feature register are dropped: fr_wr_i reaches no state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_valid_o <= 1'b0;
         rd_data_o  <= 64'h0000_0000_0000_0000;
      end else begin
         rd_valid_o <= rd_req_i.valid;
         if (rd_req_i.valid)
            rd_data_o <= next_rd_data;                     // [RULE_21]
      end
   end

   // Feature writes are only watched by the checks below
   logic feature_wr;
   assign feature_wr = fr_wr_i;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence rd_issued;
      rd_req_i.valid && rd_req_i.kind == erf_pkg::ERF_RD_64;
   endsequence

   sequence rd_low_issued;
      rd_req_i.valid && rd_req_i.kind == erf_pkg::ERF_RD_LOW;
   endsequence

   sequence rd_high_issued;
      rd_req_i.valid && rd_req_i.kind == erf_pkg::ERF_RD_HIGH;
   endsequence

   sequence rd_mmio_issued;
      rd_req_i.valid && rd_req_i.kind == erf_pkg::ERF_RD_MMIO;
   endsequence

   // The selected record is the one that owns the feature word
   sequence first_selected;
      32'(record_select_index_i) == FIRST_RECORD
      && FIRST_RECORD < IMPL_RECORDS;
   endsequence

   // A control write that names the owning record and is not blocked
   sequence enable_write_taken;
      ctrl_wr_i && !recovery_reset_i && CTRL_ENABLE
      && 32'(ctrl_wr_record_i) == FIRST_RECORD;
   endsequence

   feature_read_a: assert property ( // [RULE_11]
      @(posedge clk_i) disable iff (rst_i)
      rd_issued |=> rd_valid_o && rd_data_o == $past(sel_word))
      else $error("64-bit feature read wrong");

   low_word_a: assert property ( // [RULE_11]
      @(posedge clk_i) disable iff (rst_i)
      rd_low_issued
      |=> rd_data_o == {32'h0000_0000, $past(sel_word[31:0])})
      else $error("low word read wrong");

   low_high_a: assert property ( // [RULE_11]
      @(posedge clk_i) disable iff (rst_i)
      rd_high_issued |=> rd_data_o[31:0] == $past(sel_word[63:32]))
      else $error("high word read wrong");

   high_upper_a: assert property ( // [RULE_11]
      @(posedge clk_i) disable iff (rst_i)
      rd_high_issued |=> rd_data_o[63:32] == 32'h0000_0000)
      else $error("high word read upper half not zero");

   valid_pulse_a: assert property ( // [RULE_11]
      @(posedge clk_i) disable iff (rst_i)
      !rd_req_i.valid |=> !rd_valid_o)
      else $error("read valid without request");

   non_first_a: assert property ( // [RULE_12]
      @(posedge clk_i) disable iff (rst_i)
      rd_issued and (32'(record_select_index_i) != FIRST_RECORD)
      |=> rd_data_o == 64'h0000_0000_0000_0000)
      else $error("non-first record not zero");

   absent_record_a: assert property ( // [RULE_09]
      @(posedge clk_i) disable iff (rst_i)
      rd_issued and (32'(record_select_index_i) >= IMPL_RECORDS)
      |=> rd_data_o == 64'h0000_0000_0000_0000)
      else $error("unimplemented record not zero");

   first_field_a: assert property ( // [RULE_08]
      @(posedge clk_i) disable iff (rst_i)
      rd_issued and first_selected |=> rd_data_o[1:0] != 2'b00)
      else $error("first record field zero");

   ext_bits_a: assert property ( // [RULE_13] [RULE_20]
      @(posedge clk_i) disable iff (rst_i)
      rd_issued and first_selected and (FEATURE_EXTENSION_FLAG == 1'b1)
      |=> rd_data_o[54:48] == SUPPORT && rd_data_o[31])
      else $error("extension fields wrong");

   // Build constants must come back unchanged through the read path
   fixed_fields_a: assert property ( // [RULE_19]
      @(posedge clk_i) disable iff (rst_i)
      rd_issued and first_selected
      |=> rd_data_o[63:55] == IMPL_HI && rd_data_o[47:32] == IMPL_MID)
      else $error("constant feature fields wrong");

   mmio_slot_a: assert property ( // [RULE_10]
      @(posedge clk_i) disable iff (rst_i)
      rd_mmio_issued and (rd_req_i.addr[5:0] != 6'h00)
      |=> rd_data_o == 64'h0000_0000_0000_0000)
      else $error("unaligned mmio read not zero");

   mmio_first_a: assert property ( // [RULE_10]
      @(posedge clk_i) disable iff (rst_i)
      rd_mmio_issued and (FIRST_RECORD < IMPL_RECORDS)
      and (rd_req_i.addr == `ERF_FR_BASE_OFFSET
           + 12'(FIRST_RECORD) * `ERF_RECORD_STRIDE)
      |=> rd_data_o == FIRST_WORD)
      else $error("mmio read of first record wrong");

   data_hold_a: assert property ( // [RULE_21]
      @(posedge clk_i) disable iff (rst_i)
      !rd_req_i.valid |=> $stable(rd_data_o))
      else $error("read data changed without a read");

   // A feature write alone must leave the enable bit as it was
   feature_write_a: assert property ( // [RULE_21]
      @(posedge clk_i) disable iff (rst_i)
      feature_wr && !ctrl_wr_i |=> $stable(report_log_enable))
      else $error("feature write changed the enable bit");

   ////////////////////////////////////////////////////////////////////////
   // Enable bit checks
   gate_record_a: assert property ( // [RULE_01]
      @(posedge clk_i) disable iff (rst_i)
      CTRL_ENABLE && !report_log_enable |=> !record_en_o && !signal_en_o)
      else $error("recorded while disabled");

   record_follow_a: assert property ( // [RULE_01]
      @(posedge clk_i) disable iff (rst_i)
      report_log_enable && err_detect_i |=> record_en_o && signal_en_o)
      else $error("error not recorded while enabled");

   silent_correct_a: assert property ( // [RULE_03]
      @(posedge clk_i) disable iff (rst_i)
      report_log_enable |=> !silent_correct_o)
      else $error("silent correction flagged while enabled");

   enable_write_a: assert property ( // [RULE_07]
      @(posedge clk_i) disable iff (rst_i)
      enable_write_taken |=> report_log_enable == $past(ctrl_wr_data_i))
      else $error("enable write did not land");

   // Any write that is refused must leave the bit alone
   write_refused_a: assert property ( // [RULE_04]
      @(posedge clk_i) disable iff (rst_i)
      !ctrl_wr_i || recovery_reset_i
      || 32'(ctrl_wr_record_i) != FIRST_RECORD
      |=> $stable(report_log_enable))
      else $error("refused enable write changed the bit");

   recovery_hold_a: assert property ( // [RULE_04]
      @(posedge clk_i) disable iff (rst_i)
      recovery_reset_i |=> $stable(report_log_enable))
      else $error("enable lost on recovery reset");

   reserved_enable_a: assert property ( // [RULE_07]
      @(posedge clk_i) disable iff (rst_i)
      !CTRL_ENABLE |-> !report_log_enable)
      else $error("reserved enable bit set");

   enable_copy_a: assert property ( // [RULE_04]
      @(posedge clk_i) disable iff (rst_i)
      report_log_enable_o == $past(report_log_enable))
      else $error("enable copy out of step");

endmodule
`default_nettype wire

// >>> tb_error_record_feature_regs.sv
/*
 Self-checking bench for the feature register and reporting enable logic.
 Assumes the design defaults apart from the overrides below. Inputs are driven
 on the falling edge and outputs are sampled there.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_error_record_feature_regs;
   localparam logic [8:0]            HI  = 9'h1a5;
   localparam logic [15:0]           MID = 16'hc33c;
   localparam logic [28:0]           LOW = 29'h0123_4567;
   localparam erf_pkg::erf_support_t SUP = 7'h54;
   logic                 clk_i, rst_i, recovery_reset_i, ctrl_wr_i;
   logic                 ctrl_wr_data_i, fr_wr_i, err_detect_i, err_corrected_i;
   logic [7:0]           record_select_index_i, ctrl_wr_record_i;
   erf_pkg::erf_rd_req_t rd_req_i;
   logic                 rd_valid_o, report_log_enable_o, record_en_o;
   logic                 signal_en_o, check_code_gen_o, silent_correct_o;
   logic [63:0]          rd_data_o;
   logic [15:0]          seed;
   int                   failures, samples_checked;

   erf_error_record_feature_regs #(.FIRST_RECORD(1), .IMPL_RECORDS(3),
      .SUPPORT(SUP), .IMPL_HI(HI), .IMPL_MID(MID), .LOW_FIELDS(LOW))
      u_erf_error_record_feature_regs (
      .clk_i(clk_i), .rst_i(rst_i), .recovery_reset_i(recovery_reset_i),
      .record_select_index_i(record_select_index_i), .rd_req_i(rd_req_i),
      .ctrl_wr_i(ctrl_wr_i), .ctrl_wr_record_i(ctrl_wr_record_i),
      .ctrl_wr_data_i(ctrl_wr_data_i), .fr_wr_i(fr_wr_i),
      .err_detect_i(err_detect_i), .err_corrected_i(err_corrected_i),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
      .report_log_enable_o(report_log_enable_o), .record_en_o(record_en_o),
      .signal_en_o(signal_en_o), .check_code_gen_o(check_code_gen_o),
      .silent_correct_o(silent_correct_o));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Only record 1, the first record, carries features
   function automatic logic [63:0] exp_feature(input logic [7:0] rec);
      if (rec != 8'h01) return 64'h0;
      return {HI, SUP, MID, 1'b1, LOW, 2'h2};
   endfunction

   function automatic logic [63:0] exp_read(input erf_pkg::erf_rd_kind_t k,
         input logic [7:0] sel, input logic [11:0] addr);
      logic [63:0] f;
      f = exp_feature(sel);
      case (k)
         erf_pkg::ERF_RD_LOW:  return {32'h0, f[31:0]};
         erf_pkg::ERF_RD_HIGH: return {32'h0, f[63:32]};
         erf_pkg::ERF_RD_64:   return f;
         default: return (addr[5:0] != 6'h0) ? 64'h0 : exp_feature({2'h0, addr[11:6]});
      endcase
   endfunction

   task automatic check(input string what, input logic [63:0] seen,
         input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error: %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("checks made %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic do_read(input erf_pkg::erf_rd_kind_t k, input logic [7:0] sel,
         input logic [11:0] addr);
      record_select_index_i = sel;
      rd_req_i = '{valid: 1'b1, kind: k, addr: addr};
      @(negedge clk_i);
      rd_req_i.valid = 1'b0;
      check("read valid", 64'(rd_valid_o), 64'h1);
      check("read data", rd_data_o, exp_read(k, sel, addr));
      // An idle edge keeps the next request apart from this release
      @(negedge clk_i);
      check("read valid pulse", 64'(rd_valid_o), 64'h0);
   endtask

   task automatic wr_enable(input logic [7:0] rec, input logic v);
      ctrl_wr_record_i = rec;
      ctrl_wr_data_i = v;
      ctrl_wr_i = 1'b1;
      @(negedge clk_i);
      ctrl_wr_i = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask

   task automatic err_check(input logic e);
      err_detect_i = 1'b1;
      err_corrected_i = 1'b1;
      repeat (3) @(negedge clk_i);
      check("record enable", 64'(record_en_o), 64'(e));
      check("signal enable", 64'(signal_en_o), 64'(e));
      check("silent correct", 64'(silent_correct_o), 64'(!e));
      check("check code gen", 64'(check_code_gen_o), 64'h1);
      err_detect_i = 1'b0;
      err_corrected_i = 1'b0;
      @(negedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Span sized well above the roughly 130 cycles the tests need
   initial begin
      repeat (4000) @(posedge clk_i);
      failures++;
      complete_run();
   end

   initial begin
      {rst_i, recovery_reset_i, ctrl_wr_i, ctrl_wr_data_i, fr_wr_i} = 5'h10;
      {err_detect_i, err_corrected_i} = 2'h0;
      {record_select_index_i, ctrl_wr_record_i} = 16'h0;
      rd_req_i = '0;
      seed = 16'h2590;
      failures = 0;
      samples_checked = 0;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      check("enable after reset", 64'(report_log_enable_o), 64'h0);
      err_check(1'b0);
      $display("test reset_and_disabled done");
      for (int r = 0; r < 5; r++) begin
         for (int k = 0; k < 4; k++) begin
            do_read(erf_pkg::erf_rd_kind_t'(k), 8'(r), {6'(r), 6'h0});
         end
      end
      do_read(erf_pkg::ERF_RD_MMIO, 8'h01, 12'h048);
      fr_wr_i = 1'b1;
      @(negedge clk_i);
      fr_wr_i = 1'b0;
      do_read(erf_pkg::ERF_RD_64, 8'h01, 12'h040);
      for (int i = 0; i < 24; i++) begin
         seed = lfsr_next(seed);
         do_read(erf_pkg::erf_rd_kind_t'(seed[5:4]), {6'h0, seed[7:6]},
            {4'h0, seed[9:8], seed[0] ? 6'h0 : seed[15:10]});
      end
      $display("test feature_reads done");
      wr_enable(8'h00, 1'b1);
      check("enable other record", 64'(report_log_enable_o), 64'h0);
      wr_enable(8'h01, 1'b1);
      check("enable set", 64'(report_log_enable_o), 64'h1);
      err_check(1'b1);
      recovery_reset_i = 1'b1;
      wr_enable(8'h01, 1'b0);
      recovery_reset_i = 1'b0;
      @(negedge clk_i);
      check("enable kept", 64'(report_log_enable_o), 64'h1);
      wr_enable(8'h01, seed[3]);
      check("enable random", 64'(report_log_enable_o), 64'(seed[3]));
      wr_enable(8'h01, 1'b1);
      rst_i = 1'b1;
      @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      check("enable cold reset", 64'(report_log_enable_o), 64'h0);
      err_check(1'b0);
      $display("test enable_control done");
      complete_run();
   end
endmodule

`default_nettype wire
